/* design/mcc_console.sv */
// Purpose: Maintenance console control between operator panel and core.
// Assumes: Panel pins are asynchronous; core and memory share clk.
// Notes:   Display or store requests arriving while memory is busy are dropped.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
module mcc_console #(
  parameter int unsigned PERIOD_CYC = mcc_pkg::PERIOD_CYC
) (
  // Clock, reset, enable
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       ce,
  // APB slave
  input  wire logic [7:0]                 paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output      logic [31:0]                prdata,
  output      logic                       pready,
  output      logic                       pslverr,
  // Operator panel
  input  wire logic [mcc_pkg::SW_N-1:0]   sw_momentary,
  input  wire logic [15:0]                address_switches,
  input  wire logic [15:0]                data_switches,
  input  wire logic                       single_step_position,
  input  wire logic [2:0]                 display_select,
  input  wire logic                       auto_start_sw,
  input  wire logic                       auto_display_sw,
  output      logic [15:0]                lamps,
  // Processor core
  output      mcc_pkg::mcc_core_cmd_type  core_cmd,
  input  wire mcc_pkg::mcc_core_stat_type core_stat,
  // Main memory
  output      mcc_pkg::mcc_mem_cmd_type   mem_cmd,
  input  wire mcc_pkg::mcc_mem_rsp_type   mem_rsp
);

  localparam int PINW = mcc_pkg::SW_N + 38;
  localparam int DBW  = $clog2(mcc_pkg::DEBOUNCE_CYC);
  localparam int PW   = $clog2(PERIOD_CYC);

  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} mcc_state_type;

  // ------------------------------------------------------------
  // Source picker
  // ------------------------------------------------------------
  function automatic logic [15:0] reg_pick(input logic [2:0] sel,
                                           input logic show_sts,
                                           input mcc_pkg::mcc_core_stat_type st);
    logic [15:0] v;
    v = 16'h0000;
    if (show_sts) begin
      v = {st.control_block_bits, st.status_bits};
    end else begin
      case (sel)
        mcc_pkg::SEL_ACCUM:     v = st.accumulator_reg;
        mcc_pkg::SEL_PROG_CNT:  v = st.program_counter;
        mcc_pkg::SEL_INDEX_ONE: v = st.index_reg_one;
        mcc_pkg::SEL_INDEX_TWO: v = st.index_reg_two;
        default:                v = 16'h0000;
      endcase
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [PINW-1:0] pin_meta_q;
  logic [PINW-1:0] pin_sync_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else if (ce) begin
      pin_meta_q <= {sw_momentary, address_switches, data_switches, single_step_position,
                     display_select, auto_start_sw, auto_display_sw};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic [mcc_pkg::SW_N-1:0] sw_s;
  logic [15:0]              addr_s;
  logic [15:0]              data_s;
  logic                     single_s;
  logic [2:0]               sel_s;
  logic                     astart_s;
  logic                     adisp_s;
  assign {sw_s, addr_s, data_s, single_s, sel_s, astart_s, adisp_s} = pin_sync_q;

  // ------------------------------------------------------------
  // Debounce and action pulses
  // ------------------------------------------------------------
  logic [DBW-1:0]           db_cnt_q [mcc_pkg::SW_N];
  logic [mcc_pkg::SW_N-1:0] deb_q;
  logic [mcc_pkg::SW_N-1:0] deb_prev_q;
  logic [mcc_pkg::SW_N-1:0] act_q;
  logic                     cont_rel_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deb_q <= '0;
      for (int i = 0; i < mcc_pkg::SW_N; i++) begin
        db_cnt_q[i] <= '0;
      end
    end else if (ce) begin
      for (int i = 0; i < mcc_pkg::SW_N; i++) begin
        if (sw_s[i] == deb_q[i]) begin
          db_cnt_q[i] <= '0;
        end else if (db_cnt_q[i] == DBW'(mcc_pkg::DEBOUNCE_CYC - 1)) begin
          db_cnt_q[i] <= '0;
          deb_q[i]    <= sw_s[i];
        end else begin
          db_cnt_q[i] <= db_cnt_q[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deb_prev_q <= '0;
      act_q      <= '0;
      cont_rel_q <= 1'b0;
    end else if (ce) begin
      deb_prev_q <= deb_q;
      act_q      <= deb_q & ~deb_prev_q;
      cont_rel_q <= deb_prev_q[mcc_pkg::SW_CONT] & ~deb_q[mcc_pkg::SW_CONT];
    end
  end

  // ------------------------------------------------------------
  // Periodic tick
  // ------------------------------------------------------------
  logic [PW-1:0] period_cnt_q;
  logic          tick_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      period_cnt_q <= '0;
      tick_q       <= 1'b0;
    end else if (ce) begin
      tick_q <= (period_cnt_q == PW'(PERIOD_CYC - 1));
      if (period_cnt_q == PW'(PERIOD_CYC - 1)) begin
        period_cnt_q <= '0;
      end else begin
        period_cnt_q <= period_cnt_q + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic       en;
  logic       do_reset;
  logic       do_stop;
  logic       do_start;
  logic       do_cont;

  assign en       = ctrl_q[mcc_pkg::CTRL_EN];
  assign do_reset = en & act_q[mcc_pkg::SW_RESET];
  assign do_stop  = en & act_q[mcc_pkg::SW_STOP] & ~do_reset;
  assign do_start = en & (act_q[mcc_pkg::SW_START] | (tick_q & astart_s))
                    & ~do_reset & ~do_stop;
  assign do_cont  = en & act_q[mcc_pkg::SW_CONT] & ~do_reset & ~do_stop & ~do_start;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_cmd <= '0;
    end else if (ce) begin
      core_cmd.init         <= 1'b0;
      core_cmd.counter_load <= 1'b0;
      core_cmd.sys_reset    <= 1'b0;
      if (do_reset) begin
        core_cmd.sys_reset <= 1'b1;
        core_cmd.run       <= 1'b0;
      end else if (do_stop) begin
        core_cmd.run <= 1'b0;
      end else if (do_start) begin
        core_cmd.init          <= 1'b1;
        core_cmd.counter_load  <= 1'b1;
        core_cmd.counter_value <= addr_s;
        core_cmd.run           <= 1'b1;
      end else if (do_cont) begin
        core_cmd.run <= 1'b1;
      end else if (core_cmd.run && single_s && core_stat.instr_done) begin
        core_cmd.run <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Store and display
  // ------------------------------------------------------------
  mcc_state_type state_q;
  logic          sel_mem;
  logic          disp_go;

  assign sel_mem = (sel_s == mcc_pkg::SEL_MEM);
  assign disp_go = en & (act_q[mcc_pkg::SW_DISP] | cont_rel_q | (tick_q & adisp_s));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      mem_cmd <= '0;
      lamps   <= 16'h0000;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (en && act_q[mcc_pkg::SW_STORE] && sel_mem) begin
            mem_cmd <= '{req: 1'b1, we: 1'b1, addr: addr_s, wdata: data_s};
            state_q <= ST_WR;
          end else if (disp_go && (sel_mem || cont_rel_q)) begin
            mem_cmd <= '{req: 1'b1, we: 1'b0, addr: addr_s, wdata: 16'h0000};
            state_q <= ST_RD;
          end else if (disp_go) begin
            lamps <= reg_pick(sel_s, ctrl_q[mcc_pkg::CTRL_STS], core_stat);
          end
        end
        ST_RD: begin
          if (mem_rsp.ack) begin
            lamps       <= mem_rsp.rdata;
            mem_cmd.req <= 1'b0;
            state_q     <= ST_IDLE;
          end
        end
        ST_WR: begin
          if (mem_rsp.ack) begin
            mem_cmd.req <= 1'b0;
            state_q     <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // APB slave, one wait state
  // ------------------------------------------------------------
  logic        apb_commit;
  logic [31:0] rd_val;

  assign apb_commit = psel & penable & pready;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      mcc_pkg::CTRL_OFF: rd_val = {30'h0000_0000, ctrl_q};
      mcc_pkg::STAT_OFF: rd_val = {28'h000_0000, single_s, sel_mem, state_q != ST_IDLE,
                                   core_cmd.run};
      mcc_pkg::LAMP_OFF: rd_val = {16'h0000, lamps};
      default:           rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl_q  <= mcc_pkg::CTRL_RST;
    end else if (ce) begin
      pready  <= psel & penable & ~pready;
      prdata  <= rd_val;
      pslverr <= (psel & penable & ~pready) &
                 ~(paddr == mcc_pkg::CTRL_OFF || paddr == mcc_pkg::STAT_OFF ||
                   paddr == mcc_pkg::LAMP_OFF);
      if (apb_commit && pwrite && paddr == mcc_pkg::CTRL_OFF) begin
        ctrl_q <= pwdata[1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_reset_halts:
    assert property (@(posedge clk) disable iff (!rstn)
      ce && do_reset |=> core_cmd.sys_reset && !core_cmd.run)
    else $error("reset action did not halt and reset core");

  a_start_loads:
    assert property (@(posedge clk) disable iff (!rstn)
      ce && do_start |=> core_cmd.init && core_cmd.counter_load && core_cmd.run
                         && core_cmd.counter_value == $past(addr_s))
    else $error("start did not load address into program counter");

  a_stop_halts:
    assert property (@(posedge clk) disable iff (!rstn)
      ce && do_stop |=> !core_cmd.run && !core_cmd.sys_reset)
    else $error("stop did not halt without reset");

  a_single_once:
    assert property (@(posedge clk) disable iff (!rstn)
      ce && core_cmd.run && single_s && core_stat.instr_done
      && !do_start && !do_cont |=> !core_cmd.run)
    else $error("single step allowed more than one instruction");

  a_store_mem_only:
    assert property (@(posedge clk) disable iff (!rstn)
      $rose(mem_cmd.req && mem_cmd.we) |-> $past(sel_mem) && $past(act_q[mcc_pkg::SW_STORE]))
    else $error("store issued outside memory position");

  a_addr_holds:
    assert property (@(posedge clk) disable iff (!rstn)
      mem_cmd.req && !mem_rsp.ack |=> $stable(mem_cmd.addr) && mem_cmd.req)
    else $error("memory address changed during access");

  a_pulse_once:
    assert property (@(posedge clk) disable iff (!rstn)
      ce && act_q[mcc_pkg::SW_START] |=> !act_q[mcc_pkg::SW_START])
    else $error("start action pulse longer than one cycle");

  a_cont_shows_mem:
    assert property (@(posedge clk) disable iff (!rstn)
      ce && en && cont_rel_q && state_q == ST_IDLE && !act_q[mcc_pkg::SW_STORE]
      |=> mem_cmd.req && !mem_cmd.we && mem_cmd.addr == $past(addr_s))
    else $error("continue release did not fetch addressed word");

  a_lamp_latch:
    assert property (@(posedge clk) disable iff (!rstn)
      ce && state_q == ST_RD && mem_rsp.ack |=> lamps == $past(mem_rsp.rdata))
    else $error("lamps do not show fetched word");

  a_status_lamps:
    assert property (@(posedge clk) disable iff (!rstn)
      ce && disp_go && state_q == ST_IDLE && !sel_mem && !cont_rel_q
      && !act_q[mcc_pkg::SW_STORE] && ctrl_q[mcc_pkg::CTRL_STS]
      |=> lamps == {$past(core_stat.control_block_bits), $past(core_stat.status_bits)})
    else $error("status bits not placed on lamps");

endmodule

/* design/mcc_pkg.sv */
// Purpose: Shared constants and carriers for the maintenance console.
// Assumes: 100 MHz system clock, APB register access.
// Notes:   Processor core, registers and memory sit outside this block.
//
// Functional notes
// - Lamps show selected value, bit by bit
// - Status low lamps, control bits high
// - Address switches give absolute address
// - Data switches give word to store
// - Start initialises core, loads counter, runs
// - Stop halts after instruction, keeps registers; console drops run at once, without waiting for instr_done
// - Continue resumes; release shows addressed word
// - Single step runs one; run continues
// - Reset halts and resets core, devices
// - Store writes data only in memory position
// - Store and display never advance address
// - Display latches register or memory word
// - Selector picks accumulator, counter, index registers, memory
// - Auto start repeats start every 2 ms
// - Auto display refreshes lamps every 2 ms
package mcc_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned PERIOD_US    = 2000;
  localparam int unsigned DEBOUNCE_US  = 5;
  localparam int unsigned PERIOD_CYC   = PERIOD_US * CLK_MHZ;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;

  // ------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF  = 8'h00;
  localparam logic [7:0] STAT_OFF  = 8'h04;
  localparam logic [7:0] LAMP_OFF  = 8'h08;
  localparam int         CTRL_EN   = 0;
  localparam int         CTRL_STS  = 1;
  localparam logic [1:0] CTRL_RST  = 2'h1;

  // ------------------------------------------------------------
  // Display selector and momentary switch positions
  // ------------------------------------------------------------
  localparam logic [2:0] SEL_ACCUM     = 3'h0;
  localparam logic [2:0] SEL_PROG_CNT  = 3'h1;
  localparam logic [2:0] SEL_INDEX_ONE = 3'h2;
  localparam logic [2:0] SEL_INDEX_TWO = 3'h3;
  localparam logic [2:0] SEL_MEM       = 3'h4;
  localparam int SW_START = 0;
  localparam int SW_STOP  = 1;
  localparam int SW_CONT  = 2;
  localparam int SW_RESET = 3;
  localparam int SW_STORE = 4;
  localparam int SW_DISP  = 5;
  localparam int SW_N     = 6;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        init;
    logic        counter_load;
    logic [15:0] counter_value;
    logic        run;
    logic        sys_reset;
  } mcc_core_cmd_type;

  typedef struct packed {
    logic        instr_done;
    logic [15:0] accumulator_reg;
    logic [15:0] program_counter;
    logic [15:0] index_reg_one;
    logic [15:0] index_reg_two;
    logic [7:0]  status_bits;
    logic [7:0]  control_block_bits;
  } mcc_core_stat_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mcc_mem_cmd_type;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } mcc_mem_rsp_type;

endpackage

/* verif/mcc_core_mem_model.sv */
// Purpose: Behavioural processor core and main memory behind the console.
// Assumes: Same clock as the console; memory answers after 1 or 5 cycles.
// Notes:   Read data toggles while no request is open so stale values never look valid.
`timescale 1ns/1ps
module mcc_core_mem_model #(
  parameter logic [15:0] ACCUM_V     = 16'hA5C3,
  parameter logic [15:0] PROG_CNT_V  = 16'h0100,
  parameter logic [15:0] INDEX_ONE_V = 16'h3C96,
  parameter logic [15:0] INDEX_TWO_V = 16'h7E18,
  parameter logic [7:0]  STS_V = 8'h91,
  parameter logic [7:0]  CBB_V = 8'h5E
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // Core side
  input  wire mcc_pkg::mcc_core_cmd_type  core_cmd,
  output      mcc_pkg::mcc_core_stat_type core_stat,
  output      logic [15:0]                instr_cnt,
  // Memory side
  input  wire mcc_pkg::mcc_mem_cmd_type   mem_cmd,
  output      mcc_pkg::mcc_mem_rsp_type   mem_rsp,
  input  wire logic                       slow
);
  logic [15:0] mem [65536];
  logic [15:0] count_q;
  logic [2:0]  div_q;
  logic [2:0]  wait_q;
  logic        done_q;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 16'(i) ^ 16'h5A5A;
    end
  end

  // ------------------------------------------------------------
  // Core: one instruction every eight cycles while run is high
  // ------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn || core_cmd.sys_reset) begin
      count_q   <= PROG_CNT_V;
      div_q     <= '0;
      done_q    <= 1'b0;
      instr_cnt <= '0;
    end else begin
      div_q  <= core_cmd.run ? div_q + 3'h1 : 3'h0;
      done_q <= core_cmd.run && (div_q == 3'h7);
      if (done_q) begin
        instr_cnt <= instr_cnt + 16'h1;
      end
      if (core_cmd.counter_load) begin
        count_q <= core_cmd.counter_value;
      end else if (done_q) begin
        count_q <= count_q + 16'h1;
      end
    end
  end

  assign core_stat = '{done_q, ACCUM_V, count_q, INDEX_ONE_V, INDEX_TWO_V, STS_V, CBB_V};

  // ------------------------------------------------------------
  // Memory: one ack per request, prompt or slow
  // ------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_rsp <= '0;
      wait_q  <= '0;
    end else begin
      mem_rsp.ack <= 1'b0;
      if (mem_cmd.req && !mem_rsp.ack) begin
        if (wait_q == (slow ? 3'h4 : 3'h0)) begin
          mem_rsp.ack   <= 1'b1;
          mem_rsp.rdata <= mem[mem_cmd.addr];
          wait_q        <= '0;
          if (mem_cmd.we) begin
            mem[mem_cmd.addr] <= mem_cmd.wdata;
          end
        end else begin
          wait_q <= wait_q + 3'h1;
        end
      end else if (!mem_rsp.ack) begin
        mem_rsp.rdata <= ~mem_rsp.rdata;
      end
    end
  end
endmodule

/* verif/test_maintenance_console_control.sv */
// Purpose: Self-checking bench for the maintenance console.
// Assumes: Short refresh period of 64 cycles; 500-cycle switch debounce.
// Notes:   Periodic modes are counted, not queued, as their ticks drift.
`timescale 1ns/1ps
module test_maintenance_console_control;
  localparam int unsigned PER = 64;
  logic                       clk = 0;
  logic                       rstn = 0;
  logic                       ce = 1;
  logic [7:0]                 paddr = '0;
  logic                       psel = 0;
  logic                       penable = 0;
  logic                       pwrite = 0;
  logic [31:0]                pwdata = '0;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [mcc_pkg::SW_N-1:0]   sw = '0;
  logic [15:0]                adr_sw = '0;
  logic [15:0]                dat_sw = '0;
  logic                       ss = 0;
  logic [2:0]                 sel = '0;
  logic                       as_sw = 0;
  logic                       ad_sw = 0;
  logic                       slow = 0;
  logic                       quiet = 0;
  logic [15:0]                lamps;
  logic [15:0]                lamp_prev;
  logic [15:0]                instr_cnt;
  logic [15:0]                a;
  logic [15:0]                d;
  logic [15:0]                n;
  logic [31:0]                rd;
  logic                       er;
  logic [15:0]                regv [4] = '{16'hA5C3, 16'h0100, 16'h3C96, 16'h7E18};
  mcc_pkg::mcc_core_cmd_type  core_cmd;
  mcc_pkg::mcc_core_stat_type core_stat;
  mcc_pkg::mcc_mem_cmd_type   mem_cmd;
  mcc_pkg::mcc_mem_rsp_type   mem_rsp;
  logic [35:0]                expq [$];
  int                         n_fail = 0;
  int                         check_count = 0;
  int                         seed = 43;
  int                         n_load = 0;
  int                         n_rd = 0;
  int                         m;

  always #5 clk = ~clk;

  mcc_console #(.PERIOD_CYC(PER)) DUT (
    .clk(clk), .rstn(rstn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_momentary(sw), .address_switches(adr_sw), .data_switches(dat_sw),
    .single_step_position(ss), .display_select(sel), .auto_start_sw(as_sw),
    .auto_display_sw(ad_sw), .lamps(lamps), .core_cmd(core_cmd), .core_stat(core_stat),
    .mem_cmd(mem_cmd), .mem_rsp(mem_rsp));

  mcc_core_mem_model model (
    .clk(clk), .rstn(rstn), .core_cmd(core_cmd), .core_stat(core_stat),
    .instr_cnt(instr_cnt), .mem_cmd(mem_cmd), .mem_rsp(mem_rsp), .slow(slow));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [35:0] ev(input logic [3:0] k, input logic [15:0] ad,
                                     input logic [15:0] dt);
    return {k, ad, dt};
  endfunction

  task automatic cmp(input string what, input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic take(input logic [35:0] got);
    if (expq.size() == 0) begin
      n_fail++;
      $display("ERROR event expected none seen %h", got);
    end else begin
      cmp("event", got, expq.pop_front());
    end
  endtask

  task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] wd);
    @(posedge clk) begin
      paddr  <= ad;
      pwrite <= w;
      pwdata <= wd;
      psel   <= 1'b1;
    end
    @(posedge clk) penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Hold past the debounce, then wait for the action to land
  task automatic press(input int b, input int hold);
    @(posedge clk) sw[b] <= 1'b1;
    repeat (hold) @(posedge clk);
    sw[b] <= 1'b0;
    repeat (700) @(posedge clk);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Monitor: each unmasked result takes the oldest note; quiet masks all but sys_reset
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      lamp_prev <= '0;
    end else begin
      if (core_cmd.counter_load) n_load++;
      if (mem_rsp.ack && !mem_cmd.we) n_rd++;
      if (mem_rsp.ack && !quiet) take(ev(mem_cmd.we ? 4'h1 : 4'h4, mem_cmd.addr,
                                    mem_cmd.we ? mem_cmd.wdata : mem_rsp.rdata));
      if (lamps !== lamp_prev && !quiet) take(ev(4'h2, '0, lamps));
      if (core_cmd.counter_load && !quiet) take(ev(4'h3, core_cmd.counter_value, '0));
      if (core_cmd.sys_reset) take(ev(4'h5, '0, '0));
      lamp_prev <= lamps;
    end
  end

  initial begin
    #1000000;
    n_fail++;
    close_out();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp("reset_out", {lamps, core_cmd}, '0);
    apb(mcc_pkg::CTRL_OFF, 1'b0, '0);
    cmp("ctrl", {rd, er}, {32'h1, 1'b0});
    apb(8'h0C, 1'b0, '0);
    cmp("unmapped", {rd, er}, {32'h0, 1'b1});
    for (int i = 0; i < 4; i++) begin
      sel <= 3'(i);
      expq.push_back(ev(4'h2, '0, regv[i]));
      press(mcc_pkg::SW_DISP, 600);
    end
    // Clock enable low: a full press must leave no trace
    ce  <= 1'b0;
    sel <= mcc_pkg::SEL_ACCUM;
    press(mcc_pkg::SW_DISP, 600);
    ce  <= 1'b1;
    cmp("ce_freeze", lamps, 16'h7E18);
    apb(mcc_pkg::CTRL_OFF, 1'b1, 32'h3);
    expq.push_back(ev(4'h2, '0, 16'h5E91));
    press(mcc_pkg::SW_DISP, 600);
    apb(mcc_pkg::LAMP_OFF, 1'b0, '0);
    cmp("lamp_reg", {rd, er}, {32'h0000_5E91, 1'b0});
    adr_sw <= 16'($random(seed));
    press(mcc_pkg::SW_STORE, 600);
    apb(mcc_pkg::CTRL_OFF, 1'b1, 32'h0);
    sel <= mcc_pkg::SEL_MEM;
    press(mcc_pkg::SW_STORE, 600);
    apb(mcc_pkg::CTRL_OFF, 1'b1, 32'h1);
    apb(mcc_pkg::STAT_OFF, 1'b0, '0);
    cmp("stat", {rd, er}, {32'h4, 1'b0});
    a = 16'($random(seed));
    d = 16'($random(seed));
    adr_sw <= a;
    dat_sw <= d;
    expq.push_back(ev(4'h1, a, d));
    press(mcc_pkg::SW_STORE, 1500);
    slow <= 1'b1;
    expq.push_back(ev(4'h4, a, d));
    expq.push_back(ev(4'h2, '0, d));
    press(mcc_pkg::SW_DISP, 600);
    expq.push_back(ev(4'h4, a, d));
    press(mcc_pkg::SW_DISP, 600);
    slow <= 1'b0;
    a = 16'($random(seed));
    adr_sw <= a;
    expq.push_back(ev(4'h3, a, '0));
    press(mcc_pkg::SW_START, 600);
    n = instr_cnt;
    repeat (200) @(posedge clk);
    cmp("running", {core_cmd.run, 16'(instr_cnt - n) > 16'd20}, 2'b11);
    press(mcc_pkg::SW_STOP, 600);
    n = instr_cnt;
    repeat (100) @(posedge clk);
    cmp("stopped", {core_cmd.run, instr_cnt}, {1'b0, n});
    ss <= 1'b1;
    expq.push_back(ev(4'h4, a, a ^ 16'h5A5A));
    expq.push_back(ev(4'h2, '0, a ^ 16'h5A5A));
    press(mcc_pkg::SW_CONT, 600);
    repeat (100) @(posedge clk);
    cmp("single", {core_cmd.run, instr_cnt}, {1'b0, 16'(n + 16'h1)});
    ss <= 1'b0;
    expq.push_back(ev(4'h3, a, '0));
    press(mcc_pkg::SW_START, 600);
    expq.push_back(ev(4'h5, '0, '0));
    press(mcc_pkg::SW_RESET, 600);
    cmp("reset_run", core_cmd.run, 1'b0);
    quiet <= 1'b1;
    as_sw <= 1'b1;
    repeat (700) @(posedge clk);
    m = n_load;
    repeat (10 * PER) @(posedge clk);
    cmp("auto_start", (n_load - m >= 9) && (n_load - m <= 11), 1'b1);
    as_sw <= 1'b0;
    repeat (700) @(posedge clk);
    m = n_load;
    repeat (3 * PER) @(posedge clk);
    cmp("auto_start_off", n_load - m, 0);
    press(mcc_pkg::SW_STOP, 600);
    ad_sw <= 1'b1;
    repeat (700) @(posedge clk);
    m = n_rd;
    a = 16'($random(seed));
    adr_sw <= a;
    repeat (10 * PER) @(posedge clk);
    cmp("auto_disp", {(n_rd - m >= 9) && (n_rd - m <= 11), lamps}, {1'b1, a ^ 16'h5A5A});
    ad_sw <= 1'b0;
    repeat (700) @(posedge clk);
    m = n_rd;
    repeat (3 * PER) @(posedge clk);
    cmp("auto_disp_off", n_rd - m, 0);
    quiet <= 1'b0;
    repeat (10) @(posedge clk);
    cmp("queue_left", expq.size(), 0);
    close_out();
  end
endmodule
